// File: dv/tb_power_mode_controller.sv
// Self-checking bench for the power-mode controller top.
// Assumes pmc_top with its default widths and a 10 MHz sys_clk; the bench drives all ports.
`timescale 1ns/100ps
`default_nettype none
module tb_power_mode_controller;
    import pmc_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, analog_en;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic instr_done = 1'b0, internal_rst_req = 1'b0, ext_rst_pin_n = 1'b1, supply_ok = 1'b1;
    logic [7:0] irq_req = 8'h00, port_pins = 8'h00, wake_en, pin_val;
    logic cpu_run, periph_clk_en, osc_en, regulator_en, clk_sel_lpo, dev_rst_n, pc_reset;
    logic irq_wake, port_match_irq;
    logic [15:0] reset_vector;
    logic [31:0] rd;
    pmc_state_t mode;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] rng = 32'd22783;

    pmc_top u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .instr_done(instr_done),
        .irq_req(irq_req), .internal_rst_req(internal_rst_req), .ext_rst_pin_n(ext_rst_pin_n),
        .supply_ok(supply_ok), .port_pins(port_pins), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
        .osc_en(osc_en), .regulator_en(regulator_en), .analog_en(analog_en), .clk_sel_lpo(clk_sel_lpo),
        .dev_rst_n(dev_rst_n), .pc_reset(pc_reset), .reset_vector(reset_vector), .irq_wake(irq_wake),
        .port_match_irq(port_match_irq), .mode(mode));

    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic conclude;
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Both channels offered together; each released at the edge that takes it
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, ar, wr, bv;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge sys_clk);
            ar = s_axi_awready;
            wr = s_axi_wready;
            @(posedge sys_clk);
            if (ar && !aw_ok) begin
                s_axi_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (wr && !w_ok) begin
                s_axi_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        s_axi_bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            bv = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge sys_clk);
        end while (!bv);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [4:0] a);
        logic ok;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge sys_clk);
            ok = s_axi_arready;
            @(posedge sys_clk);
        end while (!ok);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ok = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge sys_clk);
        end while (!ok);
        s_axi_rready <= 1'b0;
    endtask

    task automatic pulse_instr;
        @(posedge sys_clk);
        instr_done <= 1'b1;
        @(posedge sys_clk);
        instr_done <= 1'b0;
    endtask

    task automatic pulse_irst;
        @(posedge sys_clk);
        internal_rst_req <= 1'b1;
        @(posedge sys_clk);
        internal_rst_req <= 1'b0;
    endtask

    // Returns at a negedge once the mode matches, outputs settled
    task automatic wait_mode(input pmc_state_t m, input string name);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (mode !== m && n < 200);
        chk(name, mode, m);
    endtask

    // Checks the mode once, 20 cycles later, despite the stimulus given
    task automatic hold_mode(input pmc_state_t m, input string name);
        repeat (20) @(negedge sys_clk);
        chk(name, mode, m);
    endtask

    // Reset exit: counter restarts at zero on the low-power oscillator
    task automatic boot_checks;
        wait_mode(ST_NORMAL, "boot mode");
        chk("pc_reset", pc_reset, 1'b1);
        chk("clk_sel_lpo", clk_sel_lpo, 1'b1);
        chk("reset_vector", reset_vector, RESET_VECTOR);
        chk("dev_rst_n", dev_rst_n, 1'b1);
        axi_rd(OFS_PWR);
        chk("pwr after reset", rd, 32'(PWR_RST));
    endtask

    initial begin
        // Long enough for every scenario, short enough to catch a hang
        repeat (30000) @(posedge sys_clk);
        err_total++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        boot_checks();
        rng = xs(rng);
        wake_en = (rng[7:0] & 8'h7f) | 8'h01;
        axi_wr(OFS_WAKE, {rng[31:8], wake_en});
        chk("wake bresp", resp, RESP_OKAY);
        axi_wr(5'h1c, rng);
        chk("unmapped bresp", resp, RESP_SLVERR);
        axi_rd(5'h1c);
        chk("unmapped rresp", resp, RESP_SLVERR);
        chk("unmapped rdata", rd, 32'h0);
        axi_rd(OFS_STAT);
        chk("status", rd, 32'(ST_NORMAL));
        // Idle entry waits for the retiring instruction
        axi_wr(OFS_PWR, 32'h1);
        hold_mode(ST_NORMAL, "idle before retire");
        pulse_instr();
        wait_mode(ST_IDLE, "idle entry");
        chk("idle cpu_run", cpu_run, 1'b0);
        chk("idle periph", periph_clk_en, 1'b1);
        chk("idle osc", osc_en, 1'b1);
        axi_rd(OFS_WAKE);
        chk("idle keeps regs", rd, 32'(wake_en));
        @(posedge sys_clk);
        irq_req <= 8'h80;
        hold_mode(ST_IDLE, "masked irq");
        @(posedge sys_clk);
        irq_req <= 8'h81;
        wait_mode(ST_NORMAL, "irq wake");
        chk("irq_wake", irq_wake, 1'b1);
        @(posedge sys_clk);
        irq_req <= 8'h00;
        axi_rd(OFS_PWR);
        chk("idle bit cleared", rd[IDLE_BIT], 1'b0);
        // Port change wakes from idle
        rng = xs(rng);
        pin_val = rng[7:0];
        @(posedge sys_clk);
        port_pins <= pin_val;
        axi_wr(OFS_PMV, 32'(pin_val));
        axi_wr(OFS_PMM, 32'hff);
        axi_wr(OFS_PWR, 32'h1);
        pulse_instr();
        wait_mode(ST_IDLE, "idle again");
        hold_mode(ST_IDLE, "pins matched");
        @(posedge sys_clk);
        port_pins <= pin_val ^ 8'h10;
        wait_mode(ST_NORMAL, "port wake");
        chk("port_match_irq", port_match_irq, 1'b1);
        // Reset ends idle with a full restart
        axi_wr(OFS_PWR, 32'h1);
        pulse_instr();
        wait_mode(ST_IDLE, "idle three");
        pulse_irst();
        wait_mode(ST_RESET, "idle reset");
        boot_checks();
        // Stop keeps the regulator and analog settings, ignores interrupts
        axi_wr(OFS_ANA, 32'ha);
        axi_wr(OFS_WAKE, 32'hff);
        axi_wr(OFS_REGM, 32'h0);
        axi_wr(OFS_PWR, 32'h2);
        pulse_instr();
        wait_mode(ST_STOP, "stop entry");
        chk("stop reg", regulator_en, 1'b1);
        chk("stop osc", osc_en, 1'b0);
        chk("stop cpu", cpu_run, 1'b0);
        chk("stop periph", periph_clk_en, 1'b0);
        chk("stop analog", analog_en, 4'ha);
        @(posedge sys_clk);
        irq_req <= 8'hff;
        port_pins <= ~port_pins;
        hold_mode(ST_STOP, "stop irq");
        @(posedge sys_clk);
        irq_req <= 8'h00;
        pulse_irst();
        wait_mode(ST_RESET, "stop reset");
        boot_checks();
        // Shutdown drops the regulator; the pin brings it back, an internal reset does not
        axi_wr(OFS_ANA, 32'hf);
        axi_wr(OFS_REGM, 32'h1 << STOP_CONFIG_BIT_BIT);
        axi_wr(OFS_PWR, 32'h2);
        pulse_instr();
        wait_mode(ST_SHUT, "shut entry");
        chk("shut reg", regulator_en, 1'b0);
        chk("shut analog", analog_en, 4'h0);
        chk("shut osc", osc_en, 1'b0);
        @(posedge sys_clk);
        internal_rst_req <= 1'b1;
        irq_req <= 8'hff;
        hold_mode(ST_SHUT, "shut ignores int reset");
        @(posedge sys_clk);
        internal_rst_req <= 1'b0;
        irq_req <= 8'h00;
        ext_rst_pin_n <= 1'b0;
        wait_mode(ST_RESET, "pin reset");
        @(posedge sys_clk);
        ext_rst_pin_n <= 1'b1;
        boot_checks();
        // Software moves the clock off the internal oscillator; reset must bring it back
        axi_wr(OFS_REGM, 32'h1 << CLKSRC_BIT);
        chk("slow clock select", clk_sel_lpo, 1'b0);
        // Low supply holds reset for as long as it lasts
        @(posedge sys_clk);
        supply_ok <= 1'b0;
        wait_mode(ST_RESET, "low supply");
        repeat (50) @(negedge sys_clk);
        chk("held mode", mode, ST_RESET);
        chk("held dev_rst_n", dev_rst_n, 1'b0);
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        boot_checks();
        conclude();
    end
endmodule
`default_nettype wire

// File: hw/pmc_pkg.sv
// Constants for the power-mode controller: register map, fields, states, timing.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port.
package pmc_pkg;
    localparam int AXI_AW = 5;
    // Register byte offsets
    localparam logic [4:0] OFS_PWR = 5'h00;
    localparam logic [4:0] OFS_REGM = 5'h04;
    localparam logic [4:0] OFS_WAKE = 5'h08;
    localparam logic [4:0] OFS_PMV = 5'h0c;
    localparam logic [4:0] OFS_PMM = 5'h10;
    localparam logic [4:0] OFS_ANA = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    // Field positions
    localparam int IDLE_BIT = 0;
    localparam int HALT_BIT = 1;
    localparam int STOP_CONFIG_BIT_BIT = 0;
    localparam int CLKSRC_BIT = 1;
    // Reset values
    localparam logic [1:0] PWR_RST = 2'h0;
    localparam logic [1:0] REGM_RST = 2'h0;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_HOLD_NS = 500;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RST_LAST = 4'(RST_HOLD_CYC - 1);
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_NORMAL = 3'h1,
        ST_IDLE = 3'h2,
        ST_STOP = 3'h3,
        ST_SHUT = 3'h4
    } pmc_state_t;
endpackage

// File: hw/pmc_top.sv
// Power-mode controller: normal, idle, stop and shutdown sequencing with
// reset hold, wake-up and an AXI4-Lite register port.
// Assumes the core pulses instr_done when an instruction retires and that
// irq_req and internal_rst_req come from logic on sys_clk.
// Operation
// - Idle request halts CPU after instruction
// - Idle keeps state, peripherals keep running
// - Enabled interrupt clears idle bit, resumes
// - Reset ends idle, restarts at 0x0000
// - Halt with stop bit clear enters stop
// - Stop halts oscillator, CPU, digital peripherals
// - Only reset leaves stop, never interrupts
// - Halt with stop bit set enters shutdown
// - Shutdown powers off regulator and analog
// - Shutdown exits on pin or power-on reset
// - Low supply holds device in reset
// - Port match wakes idle or interrupts
// - Reset exit resets PC, selects oscillator
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pmc_top #(
    parameter int IRQ_W = 8,
    parameter int PORT_W = 8,
    parameter int ANA_W = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AXI4-Lite write
    input wire logic [pmc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [pmc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core events
    input wire logic instr_done,
    input wire logic [IRQ_W-1:0] irq_req,
    input wire logic internal_rst_req,
    // Pins
    input wire logic ext_rst_pin_n,
    input wire logic supply_ok,
    input wire logic [PORT_W-1:0] port_pins,
    // Power and clock controls
    output logic cpu_run,
    output logic periph_clk_en,
    output logic osc_en,
    output logic regulator_en,
    output logic [ANA_W-1:0] analog_en,
    output logic clk_sel_lpo,
    // Reset and wake
    output logic dev_rst_n,
    output logic pc_reset,
    output logic [15:0] reset_vector,
    output logic irq_wake,
    output logic port_match_irq,
    output pmc_pkg::pmc_state_t mode
);
    import pmc_pkg::*;

    if (IRQ_W < 1 || IRQ_W > 32 || PORT_W < 1 || PORT_W > 32 || ANA_W < 1 || ANA_W > 32) begin : g_chk
        $error("pmc_top: widths must lie in 1..32");
    end

    function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Pin synchronisers; only the second stage is read
    logic [PORT_W+1:0] sync1_r;
    logic [PORT_W+1:0] sync2_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {ext_rst_pin_n, supply_ok, port_pins};
            sync2_r <= sync1_r;
        end
    end
    logic pin_ok;
    logic sup_ok;
    logic [PORT_W-1:0] pins_s;
    assign pin_ok = sync2_r[PORT_W+1];
    assign sup_ok = sync2_r[PORT_W];
    assign pins_s = sync2_r[PORT_W-1:0];

    // Registers and state
    pmc_state_t state_r, state_nxt;
    logic [3:0] hold_r, hold_nxt;
    logic [1:0] pwr_r, pwr_nxt;
    logic [1:0] regm_r, regm_nxt;
    logic [IRQ_W-1:0] wake_r, wake_nxt;
    logic [PORT_W-1:0] pmv_r, pmv_nxt;
    logic [PORT_W-1:0] pmm_r, pmm_nxt;
    logic [ANA_W-1:0] ana_r, ana_nxt;
    logic miss_r, miss_nxt;

    // Bus state
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [4:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    // Outputs
    logic cpu_run_r, cpu_run_nxt;
    logic pclk_r, pclk_nxt;
    logic osc_r, osc_nxt;
    logic reg_en_r, reg_en_nxt;
    logic [ANA_W-1:0] ana_en_r, ana_en_nxt;
    logic lpo_r, lpo_nxt;
    logic drst_n_r, drst_n_nxt;
    logic pcr_r, pcr_nxt;
    logic wkirq_r, wkirq_nxt;
    logic pmirq_r, pmirq_nxt;

    logic rst_any;
    logic miss;
    logic pm_evt;
    logic irq_hit;
    logic wake;
    logic do_wr;

    assign rst_any = !sup_ok || !pin_ok || (internal_rst_req && state_r != ST_SHUT);
    assign miss = |((pins_s ^ pmv_r) & pmm_r);
    assign pm_evt = miss && !miss_r && (state_r == ST_NORMAL || state_r == ST_IDLE);
    assign irq_hit = |(irq_req & wake_r);
    assign wake = irq_hit || pm_evt;
    assign do_wr = aw_held_r && w_held_r && !bvalid_r;

    function automatic logic [31:0] rd_word(input logic [4:0] a, input logic [1:0] p,
                                            input logic [1:0] m, input logic [IRQ_W-1:0] w,
                                            input logic [PORT_W-1:0] v, input logic [PORT_W-1:0] k,
                                            input logic [ANA_W-1:0] n, input pmc_state_t s);
        logic [31:0] r;
        r = '0;
        case (a)
            OFS_PWR: r = 32'(p);
            OFS_REGM: r = 32'(m);
            OFS_WAKE: r = 32'(w);
            OFS_PMV: r = 32'(v);
            OFS_PMM: r = 32'(k);
            OFS_ANA: r = 32'(n);
            OFS_STAT: r = 32'(s);
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [4:0] a);
        return a == OFS_PWR || a == OFS_REGM || a == OFS_WAKE || a == OFS_PMV ||
               a == OFS_PMM || a == OFS_ANA || a == OFS_STAT;
    endfunction

    // Bus slave
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_word(s_axi_araddr, pwr_r, regm_r, wake_r, pmv_r, pmm_r, ana_r, state_r);
            rresp_nxt = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Mode sequencer and control registers
    always_comb begin
        state_nxt = state_r;
        hold_nxt = hold_r;
        pwr_nxt = pwr_r;
        regm_nxt = regm_r;
        wake_nxt = wake_r;
        pmv_nxt = pmv_r;
        pmm_nxt = pmm_r;
        ana_nxt = ana_r;
        miss_nxt = miss;
        pcr_nxt = 1'b0;
        wkirq_nxt = 1'b0;
        pmirq_nxt = pm_evt;
        if (do_wr) begin
            case (awaddr_r)
                OFS_PWR: pwr_nxt = 2'(wmask(32'(pwr_r), wdata_r, wstrb_r));
                OFS_REGM: regm_nxt = 2'(wmask(32'(regm_r), wdata_r, wstrb_r));
                OFS_WAKE: wake_nxt = IRQ_W'(wmask(32'(wake_r), wdata_r, wstrb_r));
                OFS_PMV: pmv_nxt = PORT_W'(wmask(32'(pmv_r), wdata_r, wstrb_r));
                OFS_PMM: pmm_nxt = PORT_W'(wmask(32'(pmm_r), wdata_r, wstrb_r));
                OFS_ANA: ana_nxt = ANA_W'(wmask(32'(ana_r), wdata_r, wstrb_r));
                default: ;
            endcase
        end
        if (rst_any) begin
            // reset sequence from any mode, stop and shutdown included; internal reset is ignored in shutdown
            state_nxt = ST_RESET;
            hold_nxt = '0;
        end else begin
            case (state_r)
                ST_RESET: begin
                    if (hold_r == RST_LAST) begin
                        state_nxt = ST_NORMAL;
                        pcr_nxt = 1'b1;
                    end else begin
                        hold_nxt = hold_r + 4'h1;
                    end
                end
                ST_NORMAL: begin
                    if (instr_done && pwr_r[HALT_BIT]) begin
                        // stop or shutdown by config bit
                        state_nxt = regm_r[STOP_CONFIG_BIT_BIT] ? ST_SHUT : ST_STOP;
                    end else if (instr_done && pwr_r[IDLE_BIT]) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (wake) begin
                        state_nxt = ST_NORMAL;
                        pwr_nxt[IDLE_BIT] = 1'b0;
                        wkirq_nxt = 1'b1;
                    end
                end
                ST_STOP: state_nxt = ST_STOP;
                ST_SHUT: state_nxt = ST_SHUT;
                default: state_nxt = ST_RESET;
            endcase
        end
        // Control bits return to defaults while reset is held; memory outside is untouched
        if (state_r == ST_RESET) begin
            pwr_nxt = PWR_RST;
            regm_nxt = REGM_RST;
            wake_nxt = '0;
            pmv_nxt = '0;
            pmm_nxt = '0;
            ana_nxt = '0;
        end
    end

    // Output decode from the next state so controls and mode change on one edge
    always_comb begin
        // peripherals run in idle, CPU halted
        cpu_run_nxt = state_nxt == ST_NORMAL;
        pclk_nxt = state_nxt == ST_NORMAL || state_nxt == ST_IDLE;
        // oscillator stops in stop and shutdown
        osc_nxt = !(state_nxt == ST_STOP || state_nxt == ST_SHUT);
        // regulator and analog off in shutdown
        reg_en_nxt = state_nxt != ST_SHUT;
        ana_en_nxt = (state_nxt == ST_SHUT) ? '0 : ana_nxt;
        // internal oscillator unless software moved it
        lpo_nxt = !regm_nxt[CLKSRC_BIT];
        drst_n_nxt = state_nxt != ST_RESET;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= ST_RESET;
            hold_r <= '0;
            pwr_r <= PWR_RST;
            regm_r <= REGM_RST;
            wake_r <= '0;
            pmv_r <= '0;
            pmm_r <= '0;
            ana_r <= '0;
            miss_r <= 1'b0;
            pcr_r <= 1'b0;
            wkirq_r <= 1'b0;
            pmirq_r <= 1'b0;
            cpu_run_r <= 1'b0;
            pclk_r <= 1'b0;
            osc_r <= 1'b1;
            reg_en_r <= 1'b1;
            ana_en_r <= '0;
            lpo_r <= 1'b1;
            drst_n_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            pwr_r <= pwr_nxt;
            regm_r <= regm_nxt;
            wake_r <= wake_nxt;
            pmv_r <= pmv_nxt;
            pmm_r <= pmm_nxt;
            ana_r <= ana_nxt;
            miss_r <= miss_nxt;
            pcr_r <= pcr_nxt;
            wkirq_r <= wkirq_nxt;
            pmirq_r <= pmirq_nxt;
            cpu_run_r <= cpu_run_nxt;
            pclk_r <= pclk_nxt;
            osc_r <= osc_nxt;
            reg_en_r <= reg_en_nxt;
            ana_en_r <= ana_en_nxt;
            lpo_r <= lpo_nxt;
            drst_n_r <= drst_n_nxt;
        end
    end

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign cpu_run = cpu_run_r;
    assign periph_clk_en = pclk_r;
    assign osc_en = osc_r;
    assign regulator_en = reg_en_r;
    assign analog_en = ana_en_r;
    assign clk_sel_lpo = lpo_r;
    assign dev_rst_n = drst_n_r;
    assign pc_reset = pcr_r;
    assign reset_vector = RESET_VECTOR;
    assign irq_wake = wkirq_r;
    assign port_match_irq = pmirq_r;
    assign mode = state_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_idle_entry;
        state_r == ST_NORMAL && instr_done && pwr_r == 2'h1 && !rst_any |=> mode == ST_IDLE && !cpu_run;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
    property p_idle_keep;
        state_r == ST_IDLE && !wake && !rst_any && !do_wr |=> $stable(pmv_r) && periph_clk_en;
    endproperty
    a_idle_keep: assert property (p_idle_keep) else $error("idle lost state");
    property p_idle_wake;
        state_r == ST_IDLE && irq_hit && !rst_any |=> cpu_run && irq_wake && !pwr_r[IDLE_BIT];
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");
    property p_pc_vec;
        pc_reset |-> $past(state_r) == ST_RESET && reset_vector == 16'h0000 && clk_sel_lpo;
    endproperty
    a_pc_vec: assert property (p_pc_vec) else $error("bad reset exit");
    property p_stop_entry;
        state_r == ST_NORMAL && instr_done && pwr_r[HALT_BIT] && !regm_r[STOP_CONFIG_BIT_BIT] && !rst_any
            |=> state_r == ST_STOP && regulator_en;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
    property p_stop_off;
        state_r == ST_STOP |-> !osc_en && !cpu_run && !periph_clk_en;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("clocks run in stop");
    property p_stop_hold;
        state_r == ST_STOP && !rst_any |=> state_r == ST_STOP;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
    property p_shut_entry;
        state_r == ST_NORMAL && instr_done && pwr_r[HALT_BIT] && regm_r[STOP_CONFIG_BIT_BIT] && !rst_any
            |=> !regulator_en && analog_en == '0 && !osc_en;
    endproperty
    a_shut_entry: assert property (p_shut_entry) else $error("shutdown not entered");
    property p_shut_off;
        state_r == ST_SHUT |-> !regulator_en && analog_en == '0;
    endproperty
    a_shut_off: assert property (p_shut_off) else $error("power on in shutdown");
    property p_shut_exit;
        state_r == ST_SHUT && sup_ok && pin_ok |=> state_r == ST_SHUT;
    endproperty
    a_shut_exit: assert property (p_shut_exit) else $error("shutdown left wrongly");
    property p_supply;
        !sup_ok |=> !dev_rst_n && state_r == ST_RESET;
    endproperty
    a_supply: assert property (p_supply) else $error("low supply not held");
    property p_pmatch;
        state_r == ST_IDLE && pm_evt && !rst_any |=> cpu_run && port_match_irq;
    endproperty
    a_pmatch: assert property (p_pmatch) else $error("port match no wake");
    c_idle_wake: cover property (state_r == ST_IDLE ##1 state_r == ST_NORMAL);
    c_stop: cover property (state_r == ST_STOP);
    c_shut: cover property (state_r == ST_SHUT);
    c_rst_exit: cover property (pc_reset);
endmodule
`default_nettype wire
